// File: sbrg_pkg.sv
// package of constants and types for the serial baud rate generator
package sbrg_pkg;
   localparam int unsigned data_w = 32;
   localparam int unsigned addr_w = 4;
   localparam logic [addr_w-1:0] off_div_low = 4'h0;
   localparam logic [addr_w-1:0] off_div_high = 4'h4;
   localparam logic [addr_w-1:0] off_ctrl = 4'h8;
   localparam logic [addr_w-1:0] off_status = 4'hc;
   localparam logic [7:0] div_low_reset = 8'h00;
   localparam logic [7:0] div_high_reset = 8'h00;
   localparam int unsigned ctrl_sync_bit = 0;
   localparam int unsigned ctrl_wide_bit = 1;
   localparam int unsigned ctrl_high_speed_bit = 2;
   localparam logic [2:0] ctrl_reset = 3'h0;
   localparam logic [5:0] prescale_slow = 6'h3f;
   localparam logic [5:0] prescale_mid = 6'h0f;
   localparam logic [5:0] prescale_fast = 6'h03;
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;

   typedef struct packed {
      logic sync_mode;
      logic wide_divisor_select;
      logic high_speed_select;
   } sbrg_mode_t;

   typedef struct packed {
      logic [15:0] baud_divisor;
      logic [5:0] prescale;
   } sbrg_ratio_t;
endpackage

// File: sbrg_ratio.sv
// mode decoder: forms divisor and prescale from mode bits
`timescale 1ns/1ps
module sbrg_ratio (
   input wire sbrg_pkg::sbrg_mode_t mode,
   input wire logic [7:0] baud_divisor_low,
   input wire logic [7:0] baud_divisor_high,
   output sbrg_pkg::sbrg_ratio_t ratio
);
   import sbrg_pkg::*;
   always_comb begin
      // pair high and low bytes; high ignored when narrow
      ratio.baud_divisor = mode.wide_divisor_select ? {baud_divisor_high, baud_divisor_low}
                                                    : {8'h00, baud_divisor_low};
      if (mode.sync_mode) begin
         ratio.prescale = prescale_fast;
      end else if (mode.wide_divisor_select) begin
         ratio.prescale = mode.high_speed_select ? prescale_fast : prescale_mid;
      end else begin
         ratio.prescale = mode.high_speed_select ? prescale_mid : prescale_slow;
      end
   end
endmodule

// File: sbrg_counter.sv
// prescaler and divisor down counter producing the bit-rate tick
`timescale 1ns/1ps
module sbrg_counter (
   input wire logic aclk,
   input wire logic aresetn,
   input wire sbrg_pkg::sbrg_ratio_t ratio,
   input wire logic restart,
   output logic bit_tick,
   output logic [15:0] count
);
   import sbrg_pkg::*;
   logic [5:0] pre;
   logic [5:0] next_pre;
   logic [15:0] next_count;
   logic next_bit_tick;

   always_comb begin
      next_pre = pre;
      next_count = count;
      next_bit_tick = 1'b0;
      if (restart) begin
         // restart from the newly written divisor
         next_pre = ratio.prescale;
         next_count = ratio.baud_divisor;
      end else if (pre != 6'h00) begin
         next_pre = pre - 6'h01;
      end else begin
         next_pre = ratio.prescale;
         if (count == 16'h0000) begin
            next_count = ratio.baud_divisor;
            next_bit_tick = 1'b1;
         end else begin
            next_count = count - 16'h0001;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre <= 6'h00;
         count <= 16'h0000;
         bit_tick <= 1'b0;
      end else begin
         pre <= next_pre;
         count <= next_count;
         bit_tick <= next_bit_tick;
      end
   end
endmodule

// File: sbrg_top.sv
// serial baud rate generator with axi4-lite register slave
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
// Function
// - low divisor byte, read/write, resets zero
// - high divisor byte, read/write, resets zero
// - low byte write restarts counter
// - high byte write restarts counter
// - narrow mode ignores high byte
// - divisor is high and low pair
// - async narrow slow: divide by 64(n+1)
// - async wide slow: divide by 16(n+1)
// - sync mode: divide by 4(n+1)
// - wide select picks sixteen-bit generator
module sbrg_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [sbrg_pkg::addr_w-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [sbrg_pkg::data_w-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [sbrg_pkg::addr_w-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [sbrg_pkg::data_w-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic bit_tick
);
   import sbrg_pkg::*;

   logic [7:0] baud_divisor_low;
   logic [7:0] baud_divisor_high;
   sbrg_mode_t mode;
   logic [addr_w-1:0] aw_addr;
   logic aw_held;
   logic [data_w-1:0] w_data;
   logic [3:0] w_strb;
   logic w_held;
   logic [7:0] next_baud_divisor_low;
   logic [7:0] next_baud_divisor_high;
   sbrg_mode_t next_mode;
   logic [addr_w-1:0] next_aw_addr;
   logic next_aw_held;
   logic [data_w-1:0] next_w_data;
   logic [3:0] next_w_strb;
   logic next_w_held;
   logic [1:0] next_bresp;
   logic next_bvalid;
   logic [data_w-1:0] next_rdata;
   logic [1:0] next_rresp;
   logic next_rvalid;
   logic do_write;
   logic restart;
   logic next_restart;
   sbrg_ratio_t ratio;
   logic [15:0] count;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_comb begin
      next_aw_addr = aw_addr;
      next_aw_held = aw_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_w_held = w_held;
      next_bresp = s_axi_bresp;
      next_bvalid = s_axi_bvalid;
      next_baud_divisor_low = baud_divisor_low;
      next_baud_divisor_high = baud_divisor_high;
      next_mode = mode;
      next_restart = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_addr = s_axi_awaddr;
         next_aw_held = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
         next_w_held = 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = resp_okay;
         unique case (aw_addr)
            off_div_low: begin
               if (w_strb[0]) begin
                  next_baud_divisor_low = w_data[7:0];
                  next_restart = 1'b1;
               end
            end
            off_div_high: begin
               if (w_strb[0]) begin
                  next_baud_divisor_high = w_data[7:0];
                  next_restart = 1'b1;
               end
            end
            off_ctrl: begin
               if (w_strb[0]) begin
                  next_mode.sync_mode = w_data[ctrl_sync_bit];
                  next_mode.wide_divisor_select = w_data[ctrl_wide_bit];
                  next_mode.high_speed_select = w_data[ctrl_high_speed_bit];
               end
            end
            off_status: begin
            end
            default: begin
               next_bresp = resp_slverr;
            end
         endcase
      end
   end

   always_comb begin
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      next_rvalid = s_axi_rvalid;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = resp_okay;
         next_rdata = '0;
         unique case (s_axi_araddr)
            off_div_low: next_rdata[7:0] = baud_divisor_low;
            off_div_high: next_rdata[7:0] = baud_divisor_high;
            off_ctrl: begin
               next_rdata[ctrl_sync_bit] = mode.sync_mode;
               next_rdata[ctrl_wide_bit] = mode.wide_divisor_select;
               next_rdata[ctrl_high_speed_bit] = mode.high_speed_select;
            end
            off_status: next_rdata[15:0] = count;
            default: next_rresp = resp_slverr;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr <= '0;
         aw_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
         w_held <= 1'b0;
         s_axi_bresp <= resp_okay;
         s_axi_bvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= resp_okay;
         s_axi_rvalid <= 1'b0;
         baud_divisor_low <= div_low_reset;
         baud_divisor_high <= div_high_reset;
         mode <= ctrl_reset;
         restart <= 1'b0;
      end else begin
         aw_addr <= next_aw_addr;
         aw_held <= next_aw_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         w_held <= next_w_held;
         s_axi_bresp <= next_bresp;
         s_axi_bvalid <= next_bvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
         s_axi_rvalid <= next_rvalid;
         baud_divisor_low <= next_baud_divisor_low;
         baud_divisor_high <= next_baud_divisor_high;
         mode <= next_mode;
         restart <= next_restart;
      end
   end

   sbrg_ratio u_ratio (
      .mode(mode),
      .baud_divisor_low(baud_divisor_low),
      .baud_divisor_high(baud_divisor_high),
      .ratio(ratio)
   );

   sbrg_counter u_counter (
      .aclk(aclk),
      .aresetn(aresetn),
      .ratio(ratio),
      .restart(restart),
      .bit_tick(bit_tick),
      .count(count)
   );

   // helper: cycles since the last tick or restart, and whether the span since the last tick kept one ratio with no restart
   logic [23:0] gap;
   logic [23:0] next_gap;
   logic clean_gap;
   logic next_clean_gap;
   sbrg_ratio_t ratio_q;

   always_comb begin
      next_gap = gap + 24'h000001;
      next_clean_gap = clean_gap;
      if (restart || bit_tick) begin
         next_gap = 24'h000000;
      end
      if (bit_tick) begin
         next_clean_gap = 1'b1;
      end
      if (restart || ratio != ratio_q) begin
         next_clean_gap = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gap <= 24'h000000;
         clean_gap <= 1'b0;
         ratio_q <= '0;
      end else begin
         gap <= next_gap;
         clean_gap <= next_clean_gap;
         ratio_q <= ratio;
      end
   end

   low_reset_a: assert property (@(posedge aclk)
      $rose(aresetn) |-> baud_divisor_low == 8'h00)
      else $error("low divisor not zero after reset");
   high_reset_a: assert property (@(posedge aclk)
      $rose(aresetn) |-> baud_divisor_high == 8'h00)
      else $error("high divisor not zero after reset");
   low_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && aw_addr == off_div_low && w_strb[0])
      |=> baud_divisor_low == $past(w_data[7:0]))
      else $error("low divisor write lost");
   high_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && aw_addr == off_div_high && w_strb[0])
      |=> baud_divisor_high == $past(w_data[7:0]))
      else $error("high divisor write lost");
   low_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == off_div_low)
      |=> s_axi_rdata == {24'h000000, $past(baud_divisor_low)})
      else $error("low divisor read wrong");
   high_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == off_div_high)
      |=> s_axi_rdata == {24'h000000, $past(baud_divisor_high)})
      else $error("high divisor read wrong");
   low_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && aw_addr == off_div_low && w_strb[0]) |=> restart ##1 !bit_tick)
      else $error("low write did not restart counter");
   high_restart_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_write && aw_addr == off_div_high && w_strb[0]) |=> restart)
      else $error("high write did not restart counter");
   restart_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
      restart |=> count == $past(ratio.baud_divisor))
      else $error("restart did not reload the divisor");
   narrow_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !mode.wide_divisor_select |-> ratio.baud_divisor[15:8] == 8'h00)
      else $error("high byte used in narrow mode");
   pair_form_a: assert property (@(posedge aclk) disable iff (!aresetn)
      mode.wide_divisor_select |-> ratio.baud_divisor == {baud_divisor_high, baud_divisor_low})
      else $error("divisor pair wrong");
   slow_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (bit_tick && clean_gap && ratio == ratio_q
       && !mode.sync_mode && !mode.wide_divisor_select && !mode.high_speed_select)
      |-> gap + 24'h000001 == 24'h000040 * ({16'h0000, baud_divisor_low} + 24'h000001))
      else $error("narrow slow period wrong");
   wide_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (bit_tick && clean_gap && ratio == ratio_q
       && !mode.sync_mode && mode.wide_divisor_select && !mode.high_speed_select)
      |-> gap + 24'h000001
          == 24'h000010 * ({8'h00, baud_divisor_high, baud_divisor_low} + 24'h000001))
      else $error("wide slow period wrong");
   sync_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (bit_tick && clean_gap && ratio == ratio_q
       && mode.sync_mode && !mode.wide_divisor_select)
      |-> gap + 24'h000001 == 24'h000004 * ({16'h0000, baud_divisor_low} + 24'h000001))
      else $error("narrow sync period wrong");
   sync_wide_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (bit_tick && clean_gap && ratio == ratio_q
       && mode.sync_mode && mode.wide_divisor_select)
      |-> gap + 24'h000001
          == 24'h000004 * ({8'h00, baud_divisor_high, baud_divisor_low} + 24'h000001))
      else $error("wide sync period wrong");
   fast_narrow_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (bit_tick && clean_gap && ratio == ratio_q
       && !mode.sync_mode && !mode.wide_divisor_select && mode.high_speed_select)
      |-> gap + 24'h000001 == 24'h000010 * ({16'h0000, baud_divisor_low} + 24'h000001))
      else $error("narrow fast period wrong");
   fast_wide_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (bit_tick && clean_gap && ratio == ratio_q
       && !mode.sync_mode && mode.wide_divisor_select && mode.high_speed_select)
      |-> gap + 24'h000001
          == 24'h000004 * ({8'h00, baud_divisor_high, baud_divisor_low} + 24'h000001))
      else $error("wide fast period wrong");
   mid_prescale_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!mode.sync_mode && mode.wide_divisor_select && !mode.high_speed_select)
      |-> ratio.prescale == 6'h0f)
      else $error("wide slow prescale wrong");
   sync_prescale_a: assert property (@(posedge aclk) disable iff (!aresetn)
      mode.sync_mode |-> ratio.prescale == 6'h03)
      else $error("sync prescale wrong");
   fast_prescale_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!mode.sync_mode && mode.high_speed_select)
      |-> ratio.prescale == (mode.wide_divisor_select ? 6'h03 : 6'h0f))
      else $error("fast prescale wrong");
endmodule

// File: sbrg_line_peer.sv
// serial line peer that measures the bit period it is given
`timescale 1ns/1ps
module sbrg_line_peer (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic bit_tick,
   output logic [31:0] period,
   output logic [31:0] ticks
);
   logic [31:0] since;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         since <= 32'h0;
         period <= 32'h0;
         ticks <= 32'h0;
      end else if (bit_tick === 1'b1) begin
         period <= since + 32'h1;
         since <= 32'h0;
         ticks <= ticks + 32'h1;
      end else begin
         since <= since + 32'h1;
      end
   end
endmodule

// File: sbrg_top_bench.sv
// self-checking testbench for the serial baud rate generator
`timescale 1ns/1ps
module sbrg_top_bench;
   import sbrg_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, bit_tick;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, period, ticks, rd_val;
   logic [1:0] bresp, rresp;
   int error_cnt = 0, cmp_count = 0, cyc = 0;
   logic [1:0] exp_resp = resp_okay;
   sbrg_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .bit_tick(bit_tick));
   sbrg_line_peer i_peer (.aclk(aclk), .aresetn(aresetn), .bit_tick(bit_tick),
      .period(period), .ticks(ticks));
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("errors %0d comparisons %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         error_cnt++;
         conclude();
      end
   end
   // write: hold each channel until its own handshake edge, then wait for the response
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic ah, wh, ta, tw, b;
      logic [1:0] rsp;
      ah = 1'b0;
      wh = 1'b0;
      b = 1'b0;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      while (!(ah && wh)) begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         ah = ah | ta;
         wh = wh | tw;
      end
      bready <= 1'b1;
      while (!b) begin
         @(negedge aclk);
         b = (bvalid === 1'b1);
         rsp = bresp;
         @(posedge aclk);
      end
      check("bresp", {30'h0, rsp}, {30'h0, exp_resp});
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      logic t, r;
      logic [1:0] rsp;
      t = 1'b0;
      r = 1'b0;
      araddr <= a;
      arvalid <= 1'b1;
      while (!t) begin
         @(negedge aclk);
         t = arready;
         @(posedge aclk);
      end
      arvalid <= 1'b0;
      rready <= 1'b1;
      while (!r) begin
         @(negedge aclk);
         r = (rvalid === 1'b1);
         d = rdata;
         rsp = rresp;
         @(posedge aclk);
      end
      rready <= 1'b0;
      check("rresp", {30'h0, rsp}, {30'h0, exp_resp});
   endtask
   task automatic wait_ticks(input int k, output int gap);
      logic [31:0] t0;
      gap = 0;
      @(negedge aclk);
      t0 = ticks;
      while (ticks < t0 + k && gap < 20000) begin
         @(negedge aclk);
         gap++;
      end
      if (gap >= 20000) begin
         error_cnt++;
         $display("Error tick wait expected %0d ticks seen %0d", k, ticks - t0);
      end
      @(posedge aclk);
   endtask
   task automatic reg_access();
      rd(off_div_low, rd_val);
      check("low reset", rd_val, 32'h0);
      rd(off_div_high, rd_val);
      check("high reset", rd_val, 32'h0);
      wr(off_div_low, 32'hffff_ffa5);
      rd(off_div_low, rd_val);
      check("low rw", rd_val, 32'h0000_00a5);
      wr(off_div_high, 32'h0000_015a);
      rd(off_div_high, rd_val);
      check("high rw", rd_val, 32'h0000_005a);
   endtask
   // refused writes: a cleared low strobe or an unmapped address leaves both divisor bytes alone
   task automatic refused_writes();
      wstrb <= 4'he;
      wr(off_div_low, 32'h0000_0033);
      wstrb <= 4'hf;
      exp_resp = resp_slverr;
      wr(4'h2, 32'h0000_0033);
      rd(4'h2, rd_val);
      exp_resp = resp_okay;
      rd(off_div_low, rd_val);
      check("low kept", rd_val, 32'h0000_00a5);
      rd(off_div_high, rd_val);
      check("high kept", rd_val, 32'h0000_005a);
   endtask
   // every combination of sync, wide and high speed, with a high byte that must count only when wide
   task automatic mode_table();
      int scale[8] = '{64, 4, 16, 4, 16, 4, 4, 4};
      int n, g;
      wr(off_div_high, 32'h1);
      for (int c = 0; c < 8; c++) begin
         n = c[1] ? 258 : 2;
         wr(off_ctrl, c);
         rd(off_ctrl, rd_val);
         check("ctrl", rd_val, c);
         wr(off_div_low, 32'h2);
         wait_ticks(2, g);
         check("period", period, scale[c] * (n + 1));
      end
   endtask
   // a write in mid-period restarts the count, so the next tick comes a full period later
   task automatic restart_case();
      int g;
      wr(off_ctrl, 32'h0);
      wr(off_div_low, 32'h9);
      wait_ticks(1, g);
      repeat (300) @(posedge aclk);
      wr(off_div_high, 32'h55);
      wait_ticks(1, g);
      check("restart high", g > 600, 1);
      repeat (300) @(posedge aclk);
      wr(off_div_low, 32'h9);
      wait_ticks(1, g);
      check("restart low", g > 600, 1);
      wait_ticks(1, g);
      check("narrow period", period, 32'd640);
   endtask
   initial begin
      aresetn = 1'b0;
      awaddr = 4'h0;
      awvalid = 1'b0;
      wdata = 32'h0;
      wstrb = 4'hf;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 4'h0;
      arvalid = 1'b0;
      rready = 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      reg_access();
      refused_writes();
      mode_table();
      restart_case();
      conclude();
   end
endmodule
